//--- src/scrb_regs.vh
// Purpose: Register offsets, field positions, reset values and timing counts of the serial configuration bank.
// Assumes: 20 MHz system clock, 8-bit addresses, 16-bit data words.
// Notes: Included by the shifter and bank design files; the synchroniser does not include it.
`ifndef SCRB_REGS_VH
`define SCRB_REGS_VH

// ***************************************************************
// Register offsets
// ***************************************************************
`define SCRB_ADDR_SOFT_RESET 8'h00
`define SCRB_ADDR_READBACK 8'h01
`define SCRB_ADDR_PATTERN_ALIGN 8'h02
`define SCRB_ADDR_RAMP_START 8'h0a
`define SCRB_ADDR_POWER_DOWN 8'h0f
`define SCRB_ADDR_NOISE_SUPPRESS 8'h14
`define SCRB_ADDR_FRAME_PATTERN 8'h1c
`define SCRB_ADDR_SEED_LOW 8'h23
`define SCRB_ADDR_SEED_HIGH 8'h24
`define SCRB_ADDR_UPPER_PAGE 8'hf0

// ***************************************************************
// Field positions
// ***************************************************************
`define SCRB_BIT_SOFT_RESET 0
`define SCRB_BIT_READBACK_EN 0
`define SCRB_BIT_UPPER_PAGE 4
`define SCRB_BIT_PATTERN_SYNC 13
`define SCRB_BIT_PARTIAL_SLEEP 8
`define SCRB_BIT_FULL_SLEEP 9
`define SCRB_BIT_SLEEP_PIN_SEL 10
`define SCRB_BIT_FRAME_PAT_EN 14
`define SCRB_SEED_HIGH_LSB 9

// ***************************************************************
// Reset values and writable masks
// ***************************************************************
`define SCRB_RESET_VALUE 16'h0000
`define SCRB_MASK_READBACK 16'h0011
`define SCRB_MASK_PATTERN_ALIGN 16'h2000
`define SCRB_MASK_POWER_DOWN 16'h07ff
`define SCRB_MASK_NOISE_SUPPRESS 16'h00ff
`define SCRB_MASK_FRAME_PATTERN 16'h7fff
`define SCRB_MASK_FULL 16'hffff

// ***************************************************************
// Serial word format and timing
// ***************************************************************
`define SCRB_WORD_BITS 24
`define SCRB_ADDR_BITS 8
`define SCRB_DATA_BITS 16
`define SCRB_CLK_HZ 20000000
`define SCRB_RESET_MIN_NS 50
`define SCRB_RESET_MIN_CYC ((`SCRB_RESET_MIN_NS * (`SCRB_CLK_HZ / 1000000) + 999) / 1000)

`endif

//--- src/scrb_sync.v
// Purpose: Two-flop synchroniser for pin inputs of the configuration bank.
// Assumes: Inputs are asynchronous to CLK_I.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps

module scrb_sync #(
	parameter WIDTH = 3
) (
	input wire clk_i,
	input wire rst_i,
	input wire [WIDTH-1:0] async_i,
	input wire [WIDTH-1:0] rst_val_i,
	output reg [WIDTH-1:0] sync_o
);

reg [WIDTH-1:0] meta_q;

always @(posedge clk_i) begin
	if (rst_i) begin
		meta_q <= rst_val_i;
		sync_o <= rst_val_i;
	end else begin
		meta_q <= async_i;
		sync_o <= meta_q;
	end
end

endmodule // scrb_sync

//--- src/scrb_shifter.v
// Purpose: Serial word receiver and readback shifter of the configuration bank.
// Assumes: Inputs are already synchronised to clk_i.
// Notes: Emits one pulse per complete 24-bit word; excess bits are dropped at deselect.
`timescale 1ns/1ps
`include "scrb_regs.vh"

module scrb_shifter (
	input wire clk_i,
	input wire rst_i,
	input wire sel_n_i,
	input wire sck_i,
	input wire sdi_i,
	input wire [15:0] rd_data_i,
	output reg [7:0] addr_o,
	output reg [15:0] data_o,
	output reg word_o,
	output reg addr_done_o,
	output reg [7:0] cur_addr_o,
	output reg sdo_o
);

reg sck_q;
reg [4:0] cnt_q;
reg [22:0] sh_q;
reg [15:0] rd_sh_q;
wire rise = sck_i & ~sck_q;
wire fall = ~sck_i & sck_q;
wire [23:0] full_word = {sh_q, sdi_i};

// ***************************************************************
// Shift in on rising edges, shift readback out on falling edges
// ***************************************************************
always @(posedge clk_i) begin
	if (rst_i) begin
		sck_q <= 1'b0;
		cnt_q <= 5'h00;
		sh_q <= 23'h000000;
		rd_sh_q <= 16'h0000;
		addr_o <= 8'h00;
		data_o <= 16'h0000;
		word_o <= 1'b0;
		addr_done_o <= 1'b0;
		cur_addr_o <= 8'h00;
		sdo_o <= 1'b0;
	end else begin
		sck_q <= sck_i;
		word_o <= 1'b0;
		addr_done_o <= 1'b0;
		if (sel_n_i) begin
			cnt_q <= 5'h00;
		end else if (rise) begin
			sh_q <= full_word[22:0];
			if (cnt_q == 5'h07) begin
				cur_addr_o <= full_word[7:0];
				addr_done_o <= 1'b1;
			end
			if (cnt_q == 5'h17) begin
				cnt_q <= 5'h00;
				addr_o <= full_word[23:16];
				data_o <= full_word[15:0];
				word_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 5'h01;
			end
		end else if (fall && cnt_q != 5'h00 && cnt_q > 5'h07) begin
			sdo_o <= rd_sh_q[15];
			rd_sh_q <= {rd_sh_q[14:0], 1'b0};
		end
		if (addr_done_o) begin
			rd_sh_q <= rd_data_i;
		end
	end
end

endmodule // scrb_shifter

//--- src/scrb_bank.v
// Purpose: Configuration register bank behind a three-wire serial write port with serial readback.
// Assumes: CLK_I at 20 MHz; shift clock, select, data and reset pins are asynchronous.
// Notes: Readback data is driven on falling shift-clock edges for sampling on the next rising edge.
// Function
// - A high-going reset pulse returns every register to its default value.
// - Readback output stays high impedance after power-up and reset until readback enabled.
// - In readback mode only address 1 is writable; selected register shifts out.
// - Address 1 cannot be read back while readback mode is active.
// - Controller sends address; device shifts D15 to D0, sampled on rising clock.
// - Clearing readback enable leaves readback, re-enables writes, floats the output.
// - Reset state is normal 14-bit operation, one wire, 14x serial, 7x/1x clocks.
// - Reset state: readback off, sleep pin global, 0 dB gain, filters off.
// - Writing one to address 00 bit D0 resets all registers then self-clears.
// - Address 01 bit D4 gates access to the register at 0xF0.
// - Address 02 bit D13 enables test pattern synchronisation.
// - Address 0A holds the 16-bit ramp start value.
// - Address 0F: per-channel power off, partial sleep D8, full sleep D9.
// - Address 0F bit D10 makes the sleep pin trigger partial, else full sleep.
// - Address 14 bits D7 to D0 enable noise suppression per channel.
// - Address 1C bit D14 makes frame clock follow the 14-bit pattern D13 to D0.
// - Seed is 23 bits: low 16 from address 23, high 7 from 24 D15-D9.
// - Several functions in one register update in a single write.
// - While selected, data sampled on rising edges; every 24th edge commits a word.
// - Each word is 8 address bits then 16 data bits; many words per select.
`timescale 1ns/1ps
`include "scrb_regs.vh"

module scrb_bank #(
	parameter CHANNELS = 8,
	parameter UPPER_PAGE_RESET = 16'h0000
) (
	input wire CLK_I,
	input wire RST_I,
	input wire PORT_SELECT_N_I,
	input wire PORT_CLK_I,
	input wire PORT_DATA_IN_I,
	input wire HW_RESET_I,
	input wire SLEEP_PIN_I,
	output reg PORT_DATA_OUT_O,
	output reg PORT_DATA_OUT_OE_N_O,
	output reg READBACK_ACTIVE_O,
	output reg UPPER_PAGE_ACCESS_ENABLE_O,
	output reg PATTERN_SYNC_ENABLE_O,
	output reg [15:0] RAMP_START_VALUE_O,
	output reg [CHANNELS-1:0] CHANNEL_POWER_OFF_O,
	output reg PARTIAL_SLEEP_O,
	output reg FULL_SLEEP_O,
	output reg [CHANNELS-1:0] CHANNEL_NOISE_SUPPRESS_O,
	output reg FRAME_PATTERN_ENABLE_O,
	output reg [13:0] FRAME_PATTERN_BITS_O,
	output reg [22:0] PRNG_START_SEED_O,
	output reg [CHANNELS-1:0] INPUT_POLARITY_SWAP_O,
	output reg [15:0] UPPER_PAGE_REG_O
);

// ***************************************************************
// Pin synchronisation
// ***************************************************************
wire [3:0] pins_sync;
wire sel_n = pins_sync[3];
wire sck = pins_sync[2];
wire sdi = pins_sync[1];
wire hw_rst = pins_sync[0];
reg sleep_meta_q;
reg sleep_q;
reg hw_rst_q;

scrb_sync #(
	.WIDTH(4)
) u_sync (
	.clk_i(CLK_I),
	.rst_i(RST_I),
	.async_i({PORT_SELECT_N_I, PORT_CLK_I, PORT_DATA_IN_I, ~HW_RESET_I}),
	.rst_val_i(4'h9),
	.sync_o(pins_sync)
);

// ***************************************************************
// Register storage
// ***************************************************************
reg [15:0] readback_q;
reg [15:0] align_q;
reg [15:0] ramp_q;
reg [15:0] power_q;
reg [15:0] noise_q;
reg [15:0] frame_q;
reg [15:0] seed_lo_q;
reg [15:0] seed_hi_q;
reg [15:0] upper_q;
reg soft_rst_q;

wire [7:0] wr_addr;
wire [15:0] wr_data;
wire word_done;
wire addr_done;
wire [7:0] cur_addr;
wire sdo;
reg [15:0] rd_mux;

wire readback_en = readback_q[`SCRB_BIT_READBACK_EN];
wire upper_en = readback_q[`SCRB_BIT_UPPER_PAGE];
wire hw_rst_edge = ~hw_rst & hw_rst_q;
wire bank_clear = RST_I | hw_rst_edge | soft_rst_q;

// Readback data selection; address 1 and unmapped addresses read zero.
always @* begin
	case (cur_addr)
	`SCRB_ADDR_PATTERN_ALIGN: rd_mux = align_q;
	`SCRB_ADDR_RAMP_START: rd_mux = ramp_q;
	`SCRB_ADDR_POWER_DOWN: rd_mux = power_q;
	`SCRB_ADDR_NOISE_SUPPRESS: rd_mux = noise_q;
	`SCRB_ADDR_FRAME_PATTERN: rd_mux = frame_q;
	`SCRB_ADDR_SEED_LOW: rd_mux = seed_lo_q;
	`SCRB_ADDR_SEED_HIGH: rd_mux = seed_hi_q;
	`SCRB_ADDR_UPPER_PAGE: rd_mux = upper_en ? upper_q : 16'h0000;
	default: rd_mux = 16'h0000;
	endcase
end

scrb_shifter u_shifter (
	.clk_i(CLK_I),
	.rst_i(RST_I),
	.sel_n_i(sel_n),
	.sck_i(sck),
	.sdi_i(sdi),
	.rd_data_i(rd_mux),
	.addr_o(wr_addr),
	.data_o(wr_data),
	.word_o(word_done),
	.addr_done_o(addr_done),
	.cur_addr_o(cur_addr),
	.sdo_o(sdo)
);

// ***************************************************************
// Write path
// ***************************************************************
wire wr_ok = word_done & (~readback_en | wr_addr == `SCRB_ADDR_READBACK);

always @(posedge CLK_I) begin
	if (RST_I) begin
		hw_rst_q <= 1'b0;
		sleep_meta_q <= 1'b0;
		sleep_q <= 1'b0;
	end else begin
		hw_rst_q <= hw_rst;
		sleep_meta_q <= SLEEP_PIN_I;
		sleep_q <= sleep_meta_q;
	end
end

always @(posedge CLK_I) begin
	if (bank_clear) begin
		readback_q <= `SCRB_RESET_VALUE;
		align_q <= `SCRB_RESET_VALUE;
		ramp_q <= `SCRB_RESET_VALUE;
		power_q <= `SCRB_RESET_VALUE;
		noise_q <= `SCRB_RESET_VALUE;
		frame_q <= `SCRB_RESET_VALUE;
		seed_lo_q <= `SCRB_RESET_VALUE;
		seed_hi_q <= `SCRB_RESET_VALUE;
		upper_q <= UPPER_PAGE_RESET;
		soft_rst_q <= 1'b0;
	end else if (wr_ok) begin
		case (wr_addr)
		`SCRB_ADDR_SOFT_RESET: soft_rst_q <= wr_data[`SCRB_BIT_SOFT_RESET];
		`SCRB_ADDR_READBACK: readback_q <= wr_data & `SCRB_MASK_READBACK;
		`SCRB_ADDR_PATTERN_ALIGN: align_q <= wr_data & `SCRB_MASK_PATTERN_ALIGN;
		`SCRB_ADDR_RAMP_START: ramp_q <= wr_data;
		`SCRB_ADDR_POWER_DOWN: power_q <= wr_data & `SCRB_MASK_POWER_DOWN;
		`SCRB_ADDR_NOISE_SUPPRESS: noise_q <= wr_data & `SCRB_MASK_NOISE_SUPPRESS;
		`SCRB_ADDR_FRAME_PATTERN: frame_q <= wr_data & `SCRB_MASK_FRAME_PATTERN;
		`SCRB_ADDR_SEED_LOW: seed_lo_q <= wr_data;
		`SCRB_ADDR_SEED_HIGH: seed_hi_q <= wr_data;
		`SCRB_ADDR_UPPER_PAGE: begin
			if (upper_en) begin
				upper_q <= wr_data;
			end
		end
		default: soft_rst_q <= 1'b0;
		endcase
	end
end

// ***************************************************************
// Registered outputs
// ***************************************************************
always @(posedge CLK_I) begin
	if (RST_I) begin
		PORT_DATA_OUT_O <= 1'b0;
		PORT_DATA_OUT_OE_N_O <= 1'b1;
		READBACK_ACTIVE_O <= 1'b0;
		UPPER_PAGE_ACCESS_ENABLE_O <= 1'b0;
		PATTERN_SYNC_ENABLE_O <= 1'b0;
		RAMP_START_VALUE_O <= 16'h0000;
		CHANNEL_POWER_OFF_O <= {CHANNELS{1'b0}};
		PARTIAL_SLEEP_O <= 1'b0;
		FULL_SLEEP_O <= 1'b0;
		CHANNEL_NOISE_SUPPRESS_O <= {CHANNELS{1'b0}};
		FRAME_PATTERN_ENABLE_O <= 1'b0;
		FRAME_PATTERN_BITS_O <= 14'h0000;
		PRNG_START_SEED_O <= 23'h000000;
		INPUT_POLARITY_SWAP_O <= {CHANNELS{1'b0}};
		UPPER_PAGE_REG_O <= 16'h0000;
	end else begin
		PORT_DATA_OUT_O <= readback_en ? sdo : 1'b0;
		PORT_DATA_OUT_OE_N_O <= ~readback_en;
		READBACK_ACTIVE_O <= readback_en;
		UPPER_PAGE_ACCESS_ENABLE_O <= upper_en;
		PATTERN_SYNC_ENABLE_O <= align_q[`SCRB_BIT_PATTERN_SYNC];
		RAMP_START_VALUE_O <= ramp_q;
		CHANNEL_POWER_OFF_O <= power_q[CHANNELS-1:0];
		PARTIAL_SLEEP_O <= power_q[`SCRB_BIT_PARTIAL_SLEEP] |
			(sleep_q & power_q[`SCRB_BIT_SLEEP_PIN_SEL]);
		FULL_SLEEP_O <= power_q[`SCRB_BIT_FULL_SLEEP] |
			(sleep_q & ~power_q[`SCRB_BIT_SLEEP_PIN_SEL]);
		CHANNEL_NOISE_SUPPRESS_O <= noise_q[CHANNELS-1:0];
		FRAME_PATTERN_ENABLE_O <= frame_q[`SCRB_BIT_FRAME_PAT_EN];
		FRAME_PATTERN_BITS_O <= frame_q[13:0];
		PRNG_START_SEED_O <= {seed_hi_q[15:`SCRB_SEED_HIGH_LSB], seed_lo_q};
		INPUT_POLARITY_SWAP_O <= seed_hi_q[CHANNELS-1:0];
		UPPER_PAGE_REG_O <= upper_q;
	end
end

endmodule // scrb_bank

//--- sim/scrb_ctl_model.sv
// Purpose: Behavioural serial controller that drives the write port and hardware reset pin.
// Assumes: Every task is entered on a falling CLK_I edge; shift clock period 400 ns.
// Notes: Readback bits are taken late in the high phase, leaving room for pin synchronisation.
`timescale 1ns/1ps

module scrb_ctl_model (
	output logic sel_n_o,
	output logic sck_o,
	output logic sdi_o,
	output logic hw_rst_o,
	input wire logic sdo_i,
	input wire logic sdo_oe_n_i
);
	initial begin
		sel_n_o = 1'b1;
		sck_o = 1'b0;
		sdi_o = 1'b0;
		hw_rst_o = 1'b0;
	end

	task automatic hw_pulse(input logic first);
		if (first)
			#1000000;
		hw_rst_o = 1'b1;
		#200;
		hw_rst_o = 1'b0;
		#400;
	endtask

	task automatic open_port();
		sel_n_o = 1'b0;
		#200;
	endtask

	// A released data line shows the inverse of its last level.
	task automatic close_port();
		#200;
		sel_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#200;
	endtask

	// A floating readback line is read as the inverse of what the pin shows.
	task automatic shift(input int n, input logic [23:0] w, output logic [15:0] rd);
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o = w[i];
			#200 sck_o = 1'b1;
			#150 rd = {rd[14:0], sdo_oe_n_i ? ~sdo_i : sdo_i};
			#50 sck_o = 1'b0;
		end
	endtask
endmodule // scrb_ctl_model

//--- sim/scrb_bank_monitor.sv
// Purpose: Concurrent checks on the ports of the configuration bank.
// Assumes: Bound into every instance of scrb_bank.
// Notes: Readback and reset relations are checked against the register outputs.
`timescale 1ns/1ps

module scrb_bank_monitor #(
	parameter CHANNELS = 8
) (
	input wire CLK_I,
	input wire RST_I,
	input wire PORT_SELECT_N_I,
	input wire HW_RESET_I,
	input wire PORT_DATA_OUT_O,
	input wire PORT_DATA_OUT_OE_N_O,
	input wire READBACK_ACTIVE_O,
	input wire UPPER_PAGE_ACCESS_ENABLE_O,
	input wire [15:0] RAMP_START_VALUE_O,
	input wire [CHANNELS-1:0] CHANNEL_NOISE_SUPPRESS_O,
	input wire [22:0] PRNG_START_SEED_O,
	input wire [15:0] UPPER_PAGE_REG_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	oe_float_a: assert property ((!READBACK_ACTIVE_O) [*3] |-> PORT_DATA_OUT_OE_N_O)
		else $error("readback output driven while readback is off");
	oe_drive_a: assert property (READBACK_ACTIVE_O [*3] |-> !PORT_DATA_OUT_OE_N_O)
		else $error("readback output not driven in readback mode");
	out_quiet_a: assert property (PORT_DATA_OUT_OE_N_O && $past(PORT_DATA_OUT_OE_N_O) |-> !PORT_DATA_OUT_O)
		else $error("readback data not quiet while floating");
	rst_clear_a: assert property (disable iff (1'b0) RST_I |=> RAMP_START_VALUE_O == 16'h0000
		&& PRNG_START_SEED_O == 23'h000000 && !READBACK_ACTIVE_O && PORT_DATA_OUT_OE_N_O)
		else $error("registers not cleared by reset");
	hw_clear_a: assert property ($fell(HW_RESET_I) |-> ##[1:8] (RAMP_START_VALUE_O == 16'h0000
		&& UPPER_PAGE_REG_O == 16'h0000 && !READBACK_ACTIVE_O))
		else $error("hardware reset pulse did not clear registers");
	rb_block_a: assert property (READBACK_ACTIVE_O && $past(READBACK_ACTIVE_O) |-> $stable(RAMP_START_VALUE_O)
		&& $stable(PRNG_START_SEED_O) && $stable(CHANNEL_NOISE_SUPPRESS_O))
		else $error("register written in readback mode");
	page_gate_a: assert property ($changed(UPPER_PAGE_REG_O) |->
		$past(UPPER_PAGE_ACCESS_ENABLE_O) || UPPER_PAGE_REG_O == 16'h0000)
		else $error("upper page written while access disabled");
	idle_hold_a: assert property ((PORT_SELECT_N_I && !HW_RESET_I) [*8] |->
		$stable(RAMP_START_VALUE_O) && $stable(PRNG_START_SEED_O))
		else $error("register changed while the port was idle");
endmodule // scrb_bank_monitor

bind scrb_bank scrb_bank_monitor #(.CHANNELS(CHANNELS)) mon_u (.CLK_I(CLK_I), .RST_I(RST_I),
	.PORT_SELECT_N_I(PORT_SELECT_N_I), .HW_RESET_I(HW_RESET_I), .PORT_DATA_OUT_O(PORT_DATA_OUT_O),
	.PORT_DATA_OUT_OE_N_O(PORT_DATA_OUT_OE_N_O), .READBACK_ACTIVE_O(READBACK_ACTIVE_O),
	.UPPER_PAGE_ACCESS_ENABLE_O(UPPER_PAGE_ACCESS_ENABLE_O), .RAMP_START_VALUE_O(RAMP_START_VALUE_O),
	.CHANNEL_NOISE_SUPPRESS_O(CHANNEL_NOISE_SUPPRESS_O), .PRNG_START_SEED_O(PRNG_START_SEED_O),
	.UPPER_PAGE_REG_O(UPPER_PAGE_REG_O));

//--- sim/tb.sv
// Purpose: Self-checking bench of the serial configuration bank.
// Assumes: 20 MHz CLK_I; the controller model drives the port and the reset pin.
// Notes: Each scenario is a task that judges the outputs; all but t_defaults drive the bank first.
`timescale 1ns/1ps

module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sleep = 1'b0;
	logic [15:0] rd;
	int errors = 0;
	int cmp_count = 0;
	wire sel_n, sck, sdi, hw_rst, sdo, sdo_oe_n, rb, page_en, sync_en, part, full, frame_en;
	wire [15:0] ramp, page_reg;
	wire [7:0] pwr, low_freq_noise_suppress, inv;
	wire [13:0] frame_bits;
	wire [22:0] seed;

	scrb_ctl_model ctl_u (.sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi), .hw_rst_o(hw_rst), .sdo_i(sdo),
		.sdo_oe_n_i(sdo_oe_n));
	scrb_bank dut_u (.CLK_I(clk), .RST_I(rst), .PORT_SELECT_N_I(sel_n), .PORT_CLK_I(sck), .PORT_DATA_IN_I(sdi),
		.HW_RESET_I(hw_rst), .SLEEP_PIN_I(sleep), .PORT_DATA_OUT_O(sdo), .PORT_DATA_OUT_OE_N_O(sdo_oe_n),
		.READBACK_ACTIVE_O(rb), .UPPER_PAGE_ACCESS_ENABLE_O(page_en), .PATTERN_SYNC_ENABLE_O(sync_en),
		.RAMP_START_VALUE_O(ramp), .CHANNEL_POWER_OFF_O(pwr), .PARTIAL_SLEEP_O(part), .FULL_SLEEP_O(full),
		.CHANNEL_NOISE_SUPPRESS_O(low_freq_noise_suppress), .FRAME_PATTERN_ENABLE_O(frame_en), .FRAME_PATTERN_BITS_O(frame_bits),
		.PRNG_START_SEED_O(seed), .INPUT_POLARITY_SWAP_O(inv), .UPPER_PAGE_REG_O(page_reg));

	initial forever #25 clk = ~clk;

	task automatic summarize();
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [22:0] exp, input logic [22:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		ctl_u.open_port();
		ctl_u.shift(24, {a, d}, rd);
		ctl_u.close_port();
	endtask

	task automatic t_defaults();
		chk("ramp", 23'h0, ramp);
		chk("rb_oe_n", 23'h1, {rb, sdo_oe_n});
		chk("sleep_low_freq_noise_suppress", 23'h0, {pwr, part, full, low_freq_noise_suppress});
	endtask

	task automatic t_fields();
		ctl_u.open_port();
		ctl_u.shift(24, 24'h0aa5c3, rd);
		ctl_u.shift(24, 24'h0f0355, rd);
		ctl_u.shift(24, 24'h1400a5, rd);
		ctl_u.shift(24, 24'h1c6abc, rd);
		ctl_u.shift(24, 24'h231234, rd);
		ctl_u.shift(24, 24'h24fe5a, rd);
		ctl_u.shift(24, 24'h022000, rd);
		ctl_u.close_port();
		chk("ramp", 23'ha5c3, ramp);
		chk("pwr", 23'h157, {pwr, part, full});
		chk("low_freq_noise_suppress", 23'ha5, low_freq_noise_suppress);
		chk("frame", 23'h6abc, {frame_en, frame_bits});
		chk("seed", 23'h7f1234, seed);
		chk("inv_sync", 23'h15a, {sync_en, inv});
	endtask

	task automatic t_sleep();
		wr(8'h0f, 16'h0400);
		sleep = 1'b1;
		repeat (6) @(negedge clk);
		chk("pin_partial", 23'h2, {part, full});
		wr(8'h0f, 16'h0000);
		chk("pin_full", 23'h1, {part, full});
		sleep = 1'b0;
		repeat (6) @(negedge clk);
		chk("pin_off", 23'h0, {part, full});
	endtask

	task automatic t_soft();
		wr(8'h00, 16'h0001);
		chk("soft_ramp", 23'h0, ramp);
		chk("soft_low_freq_noise_suppress", 23'h0, low_freq_noise_suppress);
		wr(8'h0a, 16'h1111);
		chk("after_soft", 23'h1111, ramp);
	endtask

	task automatic t_page();
		wr(8'hf0, 16'h1234);
		chk("page_locked", 23'h0, page_reg);
		wr(8'h01, 16'h0010);
		wr(8'hf0, 16'h4321);
		chk("page_open", 23'h14321, {page_en, page_reg});
	endtask

	task automatic t_readback();
		wr(8'h0a, 16'hc35a);
		wr(8'h01, 16'h0001);
		chk("rb_on", 23'h2, {rb, sdo_oe_n});
		wr(8'h0a, 16'h0000);
		chk("rb_blocked", 23'hc35a, ramp);
		wr(8'h0a, 16'h0000);
		chk("rb_data", 23'hc35a, rd);
		wr(8'h01, 16'h0000);
		chk("rb_self", 23'h0, rd);
		chk("rb_off", 23'h1, {rb, sdo_oe_n});
		wr(8'h0a, 16'h0bad);
		chk("rb_rewrite", 23'h0bad, ramp);
	endtask

	task automatic t_excess();
		ctl_u.open_port();
		ctl_u.shift(10, 24'h0003ff, rd);
		ctl_u.close_port();
		chk("partial", 23'h0bad, ramp);
		ctl_u.open_port();
		ctl_u.shift(24, 24'h0a7777, rd);
		ctl_u.shift(10, 24'h0003ff, rd);
		ctl_u.close_port();
		chk("excess", 23'h7777, ramp);
	endtask

	task automatic t_hw();
		wr(8'h23, 16'h5555);
		chk("hw_seed_set", 23'h5555, seed);
		ctl_u.hw_pulse(1'b0);
		chk("hw_clear", 23'h0, {ramp, page_en});
		chk("hw_seed", 23'h0, seed);
	endtask

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_defaults();
		ctl_u.hw_pulse(1'b1);
		t_fields();
		t_sleep();
		t_soft();
		t_page();
		t_readback();
		t_excess();
		t_hw();
		summarize();
	end

	initial begin
		#3000000;
		errors++;
		summarize();
	end
endmodule // tb
